//--- design/sio_map.vh
`ifndef SIO_MAP_VH
`define SIO_MAP_VH
// ==========================================================
// Register byte addresses
`define SIO_A_IN_SEL 8'h00
`define SIO_A_FILT 8'h04
`define SIO_A_OUT_SEL 8'h08
`define SIO_A_SCAN 8'h0C
`define SIO_A_ACTIVE 8'h10
`define SIO_A_SET1 8'h14
`define SIO_A_SET2 8'h18
`define SIO_A_GATE 8'h1C
`define SIO_A_CNT1 8'h20
`define SIO_A_CNT2 8'h24
`define SIO_A_KNOB_A 8'h28
`define SIO_A_KNOB_B 8'h2C
`define SIO_A_FREQ 8'h30
`define SIO_A_PCTL 8'h34
`define SIO_A_DUTY 8'h38
`define SIO_A_INPUTS 8'h3C
// ==========================================================
// Input select field positions
`define SIO_IS_FILT_EN 15
`define SIO_IS_FILT_OFF 14
`define SIO_IS_CH2 13
`define SIO_IS_CH1 12
`define SIO_IS_QUAD 11
`define SIO_IS_SPEED 10
`define SIO_IS_I2_FALL 7
`define SIO_IS_I2_RISE 6
`define SIO_IS_I1_FALL 3
`define SIO_IS_I1_RISE 2
`define SIO_IS_RSV9 9
`define SIO_IS_RSV8 8
`define SIO_IS_RSV5 5
`define SIO_IS_RSV4 4
`define SIO_IS_HSC 2'h3
`define SIO_IS_INT 2'h1
// ==========================================================
// Output select codes
`define SIO_OS_CWCCW 3'h3
`define SIO_OS_PLSDIR 3'h7
`define SIO_OS_PWM 3'h1
// ==========================================================
// Values and limits
`define SIO_FILT_DEFAULT 4'hA
`define SIO_KNOB_MAX 10'h3E8
`define SIO_FREQ_MIN 13'h0032
`define SIO_FREQ_MAX 13'h1388
`define SIO_DUTY_MAX 7'h64
`define SIO_WIN_STEP_MS 4'hA
`define SIO_RESP_OK 2'h0
`define SIO_RESP_ERR 2'h2
`endif

//--- design/sio_input_filter.v
`timescale 1ns/1ps
`include "sio_map.vh"
module sio_input_filter #(
  parameter N = 8
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire tick_ms_i,
  input wire [3:0] delay_ms_i,
  input wire [N-1:0] raw_i,
  output wire [N-1:0] filt_o
);
  // ==========================================================
  // Per-input delay filter
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_bit
      reg [3:0] cnt_q;
      reg out_q;
      assign filt_o[g] = out_q;
      // Same delay for rising and falling change; a bounce restarts it
      always @(posedge clk_i) begin
        if (!rst_n_i) begin
          cnt_q <= 4'h0;
          out_q <= 1'b0;
        end else if (raw_i[g] == out_q) begin
          cnt_q <= 4'h0;
        end else if (delay_ms_i == 4'h0) begin
          out_q <= raw_i[g];
        end else if (tick_ms_i) begin
          if (cnt_q + 4'h1 >= delay_ms_i) begin
            out_q <= raw_i[g];
            cnt_q <= 4'h0;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
      end
    end
  endgenerate
endmodule

//--- design/sio_count_channel.v
`timescale 1ns/1ps
`include "sio_map.vh"
module sio_count_channel (
  input wire clk_i,
  input wire rst_n_i,
  input wire tick_ms_i,
  input wire enable_i,
  input wire speed_i,
  input wire gate_i,
  input wire count_edge_i,
  input wire reset_in_i,
  input wire [15:0] set_i,
  output wire [15:0] value_o
);
  // ==========================================================
  // Up ring counter or windowed speed counter
  reg [15:0] cnt_q;
  reg [15:0] hold_q;
  reg [10:0] win_q;
  wire [10:0] win_len = {4'h0, set_i[6:0]} * {7'h00, `SIO_WIN_STEP_MS};
  wire run = enable_i & gate_i;
  assign value_o = speed_i ? hold_q : cnt_q;
  always @(posedge clk_i) begin
    if (!rst_n_i || !run) begin
      cnt_q <= 16'h0000;
      hold_q <= 16'h0000;
      win_q <= 11'h000;
    end else if (speed_i) begin
      // Window closes on the ms tick; the edge in that cycle counts in the closing window
      if (tick_ms_i && win_q + 11'h001 >= win_len) begin
        hold_q <= cnt_q + {15'h0000, count_edge_i};
        cnt_q <= 16'h0000;
        win_q <= 11'h000;
      end else begin
        if (tick_ms_i) begin
          win_q <= win_q + 11'h001;
        end
        if (count_edge_i) begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end else if (reset_in_i) begin
      cnt_q <= 16'h0000;
    end else if (count_edge_i) begin
      // Ring at the set value; zero set value runs free over 16 bits
      if (set_i != 16'h0000 && cnt_q + 16'h0001 >= set_i) begin
        cnt_q <= 16'h0000;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule

//--- design/sio_mode_ctrl.v
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "sio_map.vh"
module sio_mode_ctrl #(
  parameter CLK_HZ = 40000000,
  parameter MS_CYCLES = 40000
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] fast_input_i,
  input wire [9:0] analog_knob_a_i,
  input wire [9:0] analog_knob_b_i,
  output wire [7:0] filtered_input_o,
  output reg routine3_start_o,
  output reg routine4_start_o,
  output reg pulse_out_point_0_o,
  output reg pulse_out_point_1_o
);
  // ==========================================================
  // Millisecond tick
  reg [31:0] div_q;
  reg tick_ms_q;
  always @(posedge clk_i) begin
    if (!rst_n_i || div_q == MS_CYCLES - 1) begin
      div_q <= 32'h0000_0000;
    end else begin
      div_q <= div_q + 32'h0000_0001;
    end
    tick_ms_q <= rst_n_i && div_q == MS_CYCLES - 1;
  end

  // ==========================================================
  // Pin synchronisers and edge history
  reg [7:0] meta_q;
  reg [7:0] sync_q;
  reg [7:0] prev_q;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
      prev_q <= 8'h00;
    end else begin
      meta_q <= fast_input_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  wire [7:0] rise = sync_q & ~prev_q;
  wire [7:0] fall = ~sync_q & prev_q;

  // ==========================================================
  // Software registers
  reg [15:0] in_sel_q;
  reg [15:0] filt_q;
  reg [15:0] out_sel_q;
  reg [15:0] set1_q;
  reg [15:0] set2_q;
  reg [1:0] gate_q;
  reg [12:0] freq_q;
  reg [1:0] pctl_q;
  reg [6:0] duty_q;
  reg scan_done_q;
  reg [15:0] act_in_q;
  reg [15:0] act_filt_q;
  reg [15:0] act_out_q;

  // ==========================================================
  // AXI4-Lite write channel: address and data in either order
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  wire aw_ok = aw_held_q || (s_axi_awvalid && s_axi_awready);
  wire w_ok = w_held_q || (s_axi_wvalid && s_axi_wready);
  wire [7:0] wa = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] ws = w_held_q ? wstrb_q : s_axi_wstrb;
  wire do_wr = aw_ok && w_ok && !s_axi_bvalid;
  wire [15:0] wd16 = {ws[1] ? wd[15:8] : 8'h00, ws[0] ? wd[7:0] : 8'h00};
  wire [15:0] wm16 = {{8{ws[1]}}, {8{ws[0]}}};
  reg wr_hit;
  always @* begin
    case (wa)
      `SIO_A_IN_SEL, `SIO_A_FILT, `SIO_A_OUT_SEL, `SIO_A_SCAN,
      `SIO_A_SET1, `SIO_A_SET2, `SIO_A_GATE, `SIO_A_FREQ,
      `SIO_A_PCTL, `SIO_A_DUTY: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Register writes; first-scan latch of the active configuration
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SIO_RESP_OK;
      in_sel_q <= 16'h0000;
      filt_q <= 16'h0000;
      out_sel_q <= 16'h0000;
      set1_q <= 16'h0000;
      set2_q <= 16'h0000;
      gate_q <= 2'h0;
      freq_q <= `SIO_FREQ_MIN;
      pctl_q <= 2'h0;
      duty_q <= 7'h00;
      scan_done_q <= 1'b0;
      act_in_q <= 16'h0000;
      act_filt_q <= 16'h0000;
      act_out_q <= 16'h0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !do_wr) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_wr) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `SIO_RESP_OK : `SIO_RESP_ERR;
        case (wa)
          `SIO_A_IN_SEL: in_sel_q <= (in_sel_q & ~wm16) | wd16;
          `SIO_A_FILT: filt_q <= (filt_q & ~wm16) | wd16;
          `SIO_A_OUT_SEL: out_sel_q <= (out_sel_q & ~wm16) | wd16;
          `SIO_A_SCAN: if (ws[0] && wd[0]) scan_done_q <= 1'b1;
          `SIO_A_SET1: set1_q <= (set1_q & ~wm16) | wd16;
          `SIO_A_SET2: set2_q <= (set2_q & ~wm16) | wd16;
          `SIO_A_GATE: if (ws[0]) gate_q <= wd[1:0];
          `SIO_A_FREQ: freq_q <= ((freq_q & ~wm16[12:0]) | wd16[12:0]);
          `SIO_A_PCTL: if (ws[0]) pctl_q <= wd[1:0];
          `SIO_A_DUTY: if (ws[0]) duty_q <= wd[6:0];
          default: ;
        endcase
      end
      // Active set follows the registers until the first scan ends
      if (!scan_done_q) begin
        act_in_q <= in_sel_q;
        act_filt_q <= filt_q;
        act_out_q <= out_sel_q;
      end
    end
  end

  // ==========================================================
  // Mode decode from the latched selections
  wire filt_en = act_in_q[`SIO_IS_FILT_EN] & ~act_in_q[`SIO_IS_FILT_OFF] &
    ~act_in_q[`SIO_IS_RSV9] & ~act_in_q[`SIO_IS_RSV8] &
    ~act_in_q[`SIO_IS_RSV5] & ~act_in_q[`SIO_IS_RSV4];
  wire [3:0] filt_ms = filt_en ? act_filt_q[3:0] :
    `SIO_FILT_DEFAULT;
  wire fast_counter = act_in_q[1:0] == `SIO_IS_HSC;
  wire speed = act_in_q[`SIO_IS_SPEED];
  wire quad = fast_counter & act_in_q[`SIO_IS_QUAD] & ~speed;
  wire ch1 = fast_counter & ~act_in_q[`SIO_IS_QUAD] & act_in_q[`SIO_IS_CH1];
  wire ch2 = fast_counter & ~act_in_q[`SIO_IS_QUAD] & act_in_q[`SIO_IS_CH2];
  wire intm = act_in_q[1:0] == `SIO_IS_INT;
  wire int1 = intm & act_in_q[`SIO_IS_CH1];
  wire int2 = intm & act_in_q[`SIO_IS_CH2];
  wire os_clean = act_out_q[12:3] == 10'h000;
  wire p_cw = os_clean & act_out_q[2:0] == `SIO_OS_CWCCW;
  wire p_pd = os_clean & act_out_q[2:0] == `SIO_OS_PLSDIR;
  wire p_pwm = os_clean & act_out_q[2:0] == `SIO_OS_PWM;

  // ==========================================================
  // Input filter on the first eight inputs
  sio_input_filter #(.N(8)) u_filter (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_ms_i(tick_ms_q),
    .delay_ms_i(filt_ms),
    .raw_i(sync_q),
    .filt_o(filtered_input_o)
  );

  // ==========================================================
  // Single phase counters; inputs bypass the filter to keep 5 kHz
  wire [15:0] val1;
  wire [15:0] val2;
  sio_count_channel u_ch1 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_ms_i(tick_ms_q),
    .enable_i(ch1),
    .speed_i(speed),
    .gate_i(gate_q[0]),
    .count_edge_i(rise[0]),
    .reset_in_i(sync_q[2]),
    .set_i(set1_q),
    .value_o(val1)
  );
  sio_count_channel u_ch2 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_ms_i(tick_ms_q),
    .enable_i(ch2),
    .speed_i(speed),
    .gate_i(gate_q[1]),
    .count_edge_i(rise[1]),
    .reset_in_i(sync_q[3]),
    .set_i(set2_q),
    .value_o(val2)
  );

  // ==========================================================
  // Quadrature counter, four counts per cycle
  reg [31:0] quad_q;
  wire q_step = (sync_q[0] ^ prev_q[0]) ^ (sync_q[1] ^ prev_q[1]);
  wire q_up = sync_q[0] ^ prev_q[1];
  always @(posedge clk_i) begin
    if (!rst_n_i || !quad || !gate_q[0] || sync_q[2]) begin
      quad_q <= 32'h0000_0000;
    end else if (q_step) begin
      quad_q <= q_up ? quad_q + 32'h0000_0001 :
        quad_q - 32'h0000_0001;
    end
  end

  // ==========================================================
  // Interrupt inputs start routines 3 and 4 on chosen edges
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      routine3_start_o <= 1'b0;
      routine4_start_o <= 1'b0;
    end else begin
      routine3_start_o <= int1 &
        ((act_in_q[`SIO_IS_I1_RISE] & rise[2]) |
         (act_in_q[`SIO_IS_I1_FALL] & fall[2]));
      routine4_start_o <= int2 &
        ((act_in_q[`SIO_IS_I2_RISE] & rise[3]) |
         (act_in_q[`SIO_IS_I2_FALL] & fall[3]));
    end
  end

  // ==========================================================
  // Knob readout, clamped so a full-scale converter shows 1000
  reg [9:0] knob_a_q;
  reg [9:0] knob_b_q;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      knob_a_q <= 10'h000;
      knob_b_q <= 10'h000;
    end else begin
      knob_a_q <= analog_knob_a_i > `SIO_KNOB_MAX ? `SIO_KNOB_MAX :
        analog_knob_a_i;
      knob_b_q <= analog_knob_b_i > `SIO_KNOB_MAX ? `SIO_KNOB_MAX :
        analog_knob_b_i;
    end
  end

  // ==========================================================
  // Pulse train: modulo accumulator toggles at twice the frequency
  wire [12:0] freq = freq_q < `SIO_FREQ_MIN ? `SIO_FREQ_MIN :
    freq_q > `SIO_FREQ_MAX ? `SIO_FREQ_MAX : freq_q;
  reg [31:0] acc_q;
  reg ptog_q;
  wire [31:0] acc_n = acc_q + {18'h00000, freq, 1'b0};
  always @(posedge clk_i) begin
    if (!rst_n_i || !(p_cw | p_pd) || !pctl_q[0]) begin
      acc_q <= 32'h0000_0000;
      ptog_q <= 1'b0;
    end else if (acc_n >= CLK_HZ) begin
      acc_q <= acc_n - CLK_HZ;
      ptog_q <= ~ptog_q;
    end else begin
      acc_q <= acc_n;
    end
  end

  // ==========================================================
  // Duty output: 100 one-ms steps per period
  reg [6:0] step_q;
  wire [6:0] duty = duty_q > `SIO_DUTY_MAX ? `SIO_DUTY_MAX : duty_q;
  always @(posedge clk_i) begin
    if (!rst_n_i || !p_pwm) begin
      step_q <= 7'h00;
    end else if (tick_ms_q) begin
      step_q <= step_q + 7'h01 >= `SIO_DUTY_MAX ? 7'h00 : step_q + 7'h01;
    end
  end

  // Output points; pulse and duty never share a point at once
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pulse_out_point_0_o <= 1'b0;
      pulse_out_point_1_o <= 1'b0;
    end else if (p_cw) begin
      pulse_out_point_0_o <= ptog_q & ~pctl_q[1];
      pulse_out_point_1_o <= ptog_q & pctl_q[1];
    end else if (p_pd) begin
      pulse_out_point_0_o <= ptog_q;
      pulse_out_point_1_o <= pctl_q[1];
    end else begin
      pulse_out_point_0_o <= p_pwm & (step_q < duty);
      pulse_out_point_1_o <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel, one cycle after the address
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SIO_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SIO_RESP_OK;
      case (s_axi_araddr)
        `SIO_A_IN_SEL: s_axi_rdata <= {16'h0000, in_sel_q};
        `SIO_A_FILT: s_axi_rdata <= {16'h0000, filt_q};
        `SIO_A_OUT_SEL: s_axi_rdata <= {16'h0000, out_sel_q};
        `SIO_A_SCAN: s_axi_rdata <= {31'h0000_0000, scan_done_q};
        `SIO_A_ACTIVE: s_axi_rdata <= {act_out_q, act_in_q};
        `SIO_A_SET1: s_axi_rdata <= {16'h0000, set1_q};
        `SIO_A_SET2: s_axi_rdata <= {16'h0000, set2_q};
        `SIO_A_GATE: s_axi_rdata <= {30'h0000_0000, gate_q};
        `SIO_A_CNT1: s_axi_rdata <= quad ? quad_q : {16'h0000, val1};
        `SIO_A_CNT2: s_axi_rdata <= {16'h0000, val2};
        `SIO_A_KNOB_A: s_axi_rdata <= {22'h000000, knob_a_q};
        `SIO_A_KNOB_B: s_axi_rdata <= {22'h000000, knob_b_q};
        `SIO_A_FREQ: s_axi_rdata <= {19'h00000, freq_q};
        `SIO_A_PCTL: s_axi_rdata <= {30'h0000_0000, pctl_q};
        `SIO_A_DUTY: s_axi_rdata <= {25'h0000000, duty_q};
        `SIO_A_INPUTS: s_axi_rdata <= {16'h0000, sync_q, filtered_input_o};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SIO_RESP_ERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

//--- dv/sio_mode_ctrl_chk.sv
`timescale 1ns/1ps
// ========
// Bus handshake and routine pulse checks at the top ports
module sio_mode_chk (
  input wire clk_i,
  input wire rst_n_i,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire routine3_start_o,
  input wire routine4_start_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Answers must hold until the master takes them
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("no write answer");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no read answer");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  // Knob words never exceed full scale
  a_knob_clamp: assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr == 8'h28 || s_axi_araddr == 8'h2C)
    |=> s_axi_rdata <= 32'h000003E8) else $error("knob above 1000");
  a_unmapped: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr > 8'h3C |=> s_axi_rresp == 2'h2
    && s_axi_rdata == 32'h00000000) else $error("unmapped read");
  // Routine starts are single cycle so one edge starts one routine
  a_r3_pulse: assert property (routine3_start_o |=> !routine3_start_o)
    else $error("routine 3 start too long");
  a_r4_pulse: assert property (routine4_start_o |=> !routine4_start_o)
    else $error("routine 4 start too long");
  c_r3: cover property (routine3_start_o);
  c_r4: cover property (routine4_start_o);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind sio_mode_ctrl sio_mode_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .routine3_start_o(routine3_start_o), .routine4_start_o(routine4_start_o));

//--- dv/sio_field_model.sv
`timescale 1ns/1ps
// ========
// Field side: sensors, encoder and knob converters
module sio_field_model #(
  parameter GAP = 8
) (
  input wire clk_i,
  output reg [7:0] pins_o,
  output reg [9:0] knob_a_o,
  output reg [9:0] knob_b_o
);
  // Knob a sits above full scale to exercise the clamp
  initial begin
    pins_o = 8'h00;
    knob_a_o = 10'h3FF;
    knob_b_o = 10'h1F4;
  end
  // Pins move just after an edge, like any field contact
  task pin(input integer i, input v);
    begin
      @(posedge clk_i);
      pins_o[i] <= v;
    end
  endtask
  // GAP cycles a level; far faster than real pulses to keep runs short
  task pulse(input integer i, input integer n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        pin(i, 1'b1);
        repeat (GAP - 1) @(posedge clk_i);
        pin(i, 1'b0);
        repeat (GAP - 1) @(posedge clk_i);
      end
    end
  endtask
  // One encoder cycle; up means phase A leads phase B
  task quad(input up);
    integer j;
    begin
      for (j = 0; j < 4; j = j + 1) begin
        pin((j % 2) ^ (up ? 0 : 1), j < 2);
        repeat (GAP) @(posedge clk_i);
      end
    end
  endtask
endmodule

//--- dv/test_sio_mode_ctrl.sv
`timescale 1ns/1ps
module test_sio_mode_ctrl;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [7:0] aw_addr = 8'h00;
  reg [7:0] ar_addr = 8'h00;
  reg [31:0] w_data = 32'h0;
  reg aw_v = 1'b0;
  reg w_v = 1'b0;
  reg b_rdy = 1'b0;
  reg ar_v = 1'b0;
  reg r_rdy = 1'b0;
  wire aw_r, w_r, b_v, ar_r, r_v, r3_o, r4_o;
  wire [1:0] b_resp, r_resp;
  wire [31:0] r_data;
  wire [7:0] pins, filt;
  wire [9:0] ka, kb;
  wire p0, p1;
  integer err_total = 0;
  integer n_checks = 0;
  integer r3 = 0;
  integer r4 = 0;
  integer p0_hi = 0;
  integer p0_up = 0;
  integer p1_up = 0;
  reg p0_l = 1'b0;
  reg p1_l = 1'b0;
  integer k;
  reg [31:0] rd;
  reg [1:0] rs;

  // ========
  // Clock, design and field side
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // One millisecond is 40 clocks; the pulse clock is scaled to match
  sio_mode_ctrl #(.CLK_HZ(40000), .MS_CYCLES(40)) dut (.clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_data), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
    .s_axi_bready(b_rdy), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_v), .s_axi_rready(r_rdy), .fast_input_i(pins),
    .analog_knob_a_i(ka), .analog_knob_b_i(kb), .filtered_input_o(filt),
    .routine3_start_o(r3_o), .routine4_start_o(r4_o),
    .pulse_out_point_0_o(p0), .pulse_out_point_1_o(p1));
  sio_field_model fm (.clk_i(clk_i), .pins_o(pins), .knob_a_o(ka),
    .knob_b_o(kb));
  // Count routine starts and output edges mid-cycle, clear of edge updates
  always @(negedge clk_i) begin
    if (r3_o === 1'b1) r3 = r3 + 1;
    if (r4_o === 1'b1) r4 = r4 + 1;
    if (p0 === 1'b1) p0_hi = p0_hi + 1;
    if (p0 === 1'b1 && p0_l === 1'b0) p0_up = p0_up + 1;
    if (p1 === 1'b1 && p1_l === 1'b0) p1_up = p1_up + 1;
    p0_l = p0;
    p1_l = p1;
  end

  // ========
  // Checking and bus tasks
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Handshakes are judged mid-cycle, released after the taking edge
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg aw_t, w_t, b_t;
    begin
      @(posedge clk_i);
      aw_addr <= a;
      w_data <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_rdy <= 1'b1;
      b_t = 1'b0;
      while (!b_t) begin
        @(negedge clk_i);
        aw_t = aw_v & aw_r;
        w_t = w_v & w_r;
        b_t = b_v & b_rdy;
        rs = b_resp;
        @(posedge clk_i);
        if (aw_t) aw_v <= 1'b0;
        if (w_t) w_v <= 1'b0;
      end
      b_rdy <= 1'b0;
      chk({30'h0, rs}, {30'h0, er});
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp, input [1:0] er);
    reg ar_t, r_t;
    begin
      @(posedge clk_i);
      ar_addr <= a;
      ar_v <= 1'b1;
      r_rdy <= 1'b1;
      r_t = 1'b0;
      while (!r_t) begin
        @(negedge clk_i);
        ar_t = ar_v & ar_r;
        r_t = r_v & r_rdy;
        rd = r_data;
        rs = r_resp;
        @(posedge clk_i);
        if (ar_t) ar_v <= 1'b0;
      end
      r_rdy <= 1'b0;
      chk(rd, exp);
      chk({30'h0, rs}, {30'h0, er});
    end
  endtask
  // Fresh power-up, then the first scan's configuration
  task cfg(input [15:0] sel, input [3:0] f, input [15:0] os);
    begin
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wr(8'h00, {16'h0, sel}, 2'h0);
      wr(8'h04, {28'h0, f}, 2'h0);
      wr(8'h08, {16'h0, os}, 2'h0);
      wr(8'h0C, 32'h1, 2'h0);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask

  // ========
  // Test sequence
  initial begin
    cfg(16'h8000, 4'h3, 16'h0);
    rdc(8'h10, 32'h8000, 2'h0);
    wr(8'h00, 32'h0803, 2'h0);
    rdc(8'h10, 32'h8000, 2'h0);
    rdc(8'h00, 32'h0803, 2'h0);
    wr(8'h40, 32'h5, 2'h2);
    rdc(8'h40, 32'h0, 2'h2);
    rdc(8'h28, 32'h3E8, 2'h0);
    rdc(8'h2C, 32'h1F4, 2'h0);
    fm.pin(5, 1'b1);
    repeat (60) @(negedge clk_i);
    chk(filt, 8'h00);
    repeat (80) @(negedge clk_i);
    chk(filt, 8'h20);
    fm.pin(5, 1'b0);
    repeat (60) @(negedge clk_i);
    chk(filt, 8'h20);
    repeat (80) @(negedge clk_i);
    chk(filt, 8'h00);
    // Every edge pairing of the two interrupt inputs
    for (k = 0; k < 4; k = k + 1) begin
      cfg(16'h3001 | (k[0] ? 16'h0008 : 16'h0004)
        | (k[1] ? 16'h0080 : 16'h0040), 4'h0, 16'h0);
      r3 = 0;
      r4 = 0;
      fm.pin(2, 1'b1);
      fm.pin(3, 1'b1);
      repeat (10) @(negedge clk_i);
      chk(r3, k[0] ? 0 : 1);
      chk(r4, k[1] ? 0 : 1);
      fm.pin(2, 1'b0);
      fm.pin(3, 1'b0);
      repeat (10) @(negedge clk_i);
      chk(r3, 1);
      chk(r4, 1);
    end
    // Filter left unselected falls back to ten milliseconds
    fm.pin(6, 1'b1);
    repeat (300) @(negedge clk_i);
    chk({31'h0, filt[6]}, 32'h0);
    repeat (140) @(negedge clk_i);
    chk({31'h0, filt[6]}, 32'h1);
    cfg(16'h0803, 4'h0, 16'h0);
    wr(8'h1C, 32'h1, 2'h0);
    fm.quad(1'b1);
    rdc(8'h20, 32'h4, 2'h0);
    fm.quad(1'b0);
    fm.quad(1'b0);
    rdc(8'h20, 32'hFFFFFFFC, 2'h0);
    cfg(16'h3003, 4'h0, 16'h0);
    wr(8'h1C, 32'h3, 2'h0);
    fm.pulse(0, 3);
    fm.pulse(1, 2);
    rdc(8'h20, 32'h3, 2'h0);
    rdc(8'h24, 32'h2, 2'h0);
    fm.pin(2, 1'b1);
    repeat (8) @(posedge clk_i);
    rdc(8'h20, 32'h0, 2'h0);
    rdc(8'h24, 32'h2, 2'h0);
    // A 10 ms window holds exactly 25 pulses of 16 clocks
    cfg(16'h1403, 4'h0, 16'h0);
    wr(8'h14, 32'h1, 2'h0);
    wr(8'h1C, 32'h1, 2'h0);
    fork
      fm.pulse(0, 60);
      begin
        repeat (850) @(posedge clk_i);
        rdc(8'h20, 32'h19, 2'h0);
      end
    join
    // Clockwise/counter-clockwise at the 5 kHz clamp: 8 clocks a period
    cfg(16'h0, 4'h0, 16'h3);
    wr(8'h30, 32'h1FFF, 2'h0);
    wr(8'h34, 32'h3, 2'h0);
    p0_up = 0;
    p1_up = 0;
    repeat (800) @(posedge clk_i);
    chk(p1_up, 100);
    chk(p0_up, 0);
    // Pulse with direction: pulses on point 0, direction level on point 1
    cfg(16'h0, 4'h0, 16'h7);
    wr(8'h30, 32'h1FFF, 2'h0);
    wr(8'h34, 32'h3, 2'h0);
    p0_up = 0;
    repeat (800) @(posedge clk_i);
    chk(p0_up, 100);
    chk({31'h0, p1}, 32'h1);
    // Half duty over one 100 ms period, then the 100 percent clamp
    cfg(16'h0, 4'h0, 16'h1);
    wr(8'h38, 32'h32, 2'h0);
    repeat (40) @(posedge clk_i);
    p0_hi = 0;
    repeat (4000) @(posedge clk_i);
    chk(p0_hi, 2000);
    wr(8'h38, 32'h7F, 2'h0);
    p0_hi = 0;
    repeat (200) @(posedge clk_i);
    chk(p0_hi, 200);
    chk({31'h0, p1}, 32'h0);
    complete_run;
  end
  // Whole sequence needs about 8200 clocks
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total = err_total + 1;
    complete_run;
  end
endmodule
